// [tb_tof_measurement_config.sv]
`timescale 1ns/1ps
module tb_tof_measurement_config;
  import tof_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic meas_done = 1'b0;
  logic meas_aborted = 1'b0;
  logic csb_n, sclk, din, lpo, stc, rsc, cal;
  tof_cfg_t cfg;
  logic [7:0] cv, sv, ce, se, d;
  logic [31:0] seed = 32'h12c1;
  logic [31:0] r;
  logic [15:0] exp_q[$];
  logic [5:0] lens[4] = '{CAL2_LEN_0, CAL2_LEN_1, CAL2_LEN_2, CAL2_LEN_3};
  int n_mismatch = 0;
  int cmp_count = 0;
  bit seen;
  always #4 sys_clk = ~sys_clk;
  tof_spi_host tof_spi_host_i (.sys_clk(sys_clk), .csb_n(csb_n), .sclk(sclk), .din(din));
  tof_measurement_config tof_measurement_config_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .csb_n(csb_n), .sclk(sclk), .din(din), .meas_done(meas_done),
    .meas_aborted(meas_aborted), .cfg(cfg), .launch_pulse_out(lpo), .status_clear(stc),
    .results_clear(rsc), .run_calibration(cal), .control_value(cv), .setup_value(sv));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Register watcher: one note per change
  // ----------------------------------------
  always @(cv or sv) begin
    if (rst_b === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected_change", 8'h00, 8'h01);
      else begin
        chk("control_value", exp_q[0][15:8], cv);
        chk("setup_value", exp_q[0][7:0], sv);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  // Launch bit holds at 1 when 0 is written, so the shadow keeps it
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [7:0] nc, ns;
    nc = (a == ADDR_CONTROL) ? (v | (ce & 8'h01)) : ce;
    ns = (a == ADDR_SETUP) ? v : se;
    if ({nc, ns} != {ce, se}) exp_q.push_back({nc, ns});
    {ce, se} = {nc, ns};
    tof_spi_host_i.send({2'b01, a, v});
    repeat (8) @(negedge sys_clk);
  endtask : wr
  task automatic pulse_chk(input logic pol);
    for (int i = 0; i < 600 && stc !== 1'b1; i++) @(negedge sys_clk);
    chk("status_clear", 8'h01, {7'h00, stc});
    chk("results_clear", 8'h01, {7'h00, rsc});
    @(negedge sys_clk);
    chk("clear_pulse_end", 8'h00, {7'h00, stc | rsc});
    for (int k = 0; k <= LAUNCH_PULSE_CYCLES; k++) begin
      chk("launch_pulse", {7'h00, pol ^ (k < LAUNCH_PULSE_CYCLES)}, {7'h00, lpo});
      @(negedge sys_clk);
    end
  endtask : pulse_chk
  initial begin
    {ce, se} = {CONTROL_RESET, SETUP_RESET};
    repeat (3) @(negedge sys_clk);
    rst_b = 1'b1;
    chk("control_reset", CONTROL_RESET, cv);
    chk("setup_reset", SETUP_RESET, sv);
    repeat (2) @(negedge sys_clk);
    chk("cal_len_reset", {2'b00, CAL2_LEN_1}, {2'b00, cfg.second_cal_length});
    for (int i = 0; i < 8; i++) begin
      r = xs();
      d = {i[1:0], r[5:0]};
      wr(ADDR_SETUP, d);
      chk("cal_len", {2'b00, lens[d[7:6]]}, {2'b00, cfg.second_cal_length});
      chk("avg", 8'h01 << d[5:3], cfg.averaging_cycles);
      chk("ends", (d[2:0] > MAX_END_CODE) ? 8'h01 : {5'h00, d[2:0]} + 8'h01,
        {5'h00, cfg.end_event_count});
    end
    for (int i = 0; i < 4; i++) begin
      r = xs();
      d = r[7:0] & 8'hFA;
      wr(ADDR_CONTROL, d);
      chk("cfg_ctl", {d[7:3], d[1], 2'b00}, {cfg.force_cal, cfg.parity_en,
        cfg.launch_pulse_polarity, cfg.end_edge_fall, cfg.begin_edge_fall,
        cfg.timing_range_select, 2'b00});
      chk("launch_idle", {7'h00, d[5]}, {7'h00, lpo});
    end
    tof_spi_host_i.send({2'b00, ADDR_CONTROL, 8'hFF});
    wr(6'h02, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      r = xs();
      d = {i[0], 1'b0, r[0], 5'h01};
      fork
        wr(ADDR_CONTROL, d);
        pulse_chk(d[5]);
      join
      wr(ADDR_CONTROL, d & 8'hFE);
      meas_aborted = i[1];
      meas_done = 1'b1;
      {ce, seen} = {ce & 8'hFE, 1'b0};
      exp_q.push_back({ce, se});
      @(negedge sys_clk);
      meas_done = 1'b0;
      seen = (cal === 1'b1);
      repeat (4) @(negedge sys_clk) seen = seen | (cal === 1'b1);
      chk("calibration", {7'h00, i[0] | ~i[1]}, {7'h00, seen});
    end
    chk("queue_empty", 8'h00, 8'(exp_q.size()));
    summarize();
  end
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule : tb_tof_measurement_config

// [tof_cfg_pkg.sv]
package tof_cfg_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [5:0] ADDR_CONTROL = 6'h00;
  localparam logic [5:0] ADDR_SETUP = 6'h01;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h40;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CMD_AUTO_BIT = 7;
  localparam int CMD_WRITE_BIT = 6;
  localparam int CTL_FORCE_CAL = 7;
  localparam int CTL_PARITY_EN = 6;
  localparam int CTL_LAUNCH_POL = 5;
  localparam int CTL_END_EDGE = 4;
  localparam int CTL_BEGIN_EDGE = 3;
  localparam int CTL_LAUNCH = 0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'hF;
  // ----------------------------------------
  // Field decode values
  // ----------------------------------------
  localparam logic [2:0] MAX_END_CODE = 3'h4;
  localparam logic [5:0] CAL2_LEN_0 = 6'h02;
  localparam logic [5:0] CAL2_LEN_1 = 6'h0A;
  localparam logic [5:0] CAL2_LEN_2 = 6'h14;
  localparam logic [5:0] CAL2_LEN_3 = 6'h28;
  localparam logic [1:0] RANGE_SHORT = 2'h0;
  localparam logic [1:0] RANGE_LONG = 2'h1;
  localparam int LAUNCH_PULSE_CYCLES = 4;

  typedef enum logic {RANGE_MODE_1, RANGE_MODE_2} range_mode_t;

  typedef struct packed {
    logic force_cal;
    logic parity_en;
    logic launch_pulse_polarity;
    logic end_edge_fall;
    logic begin_edge_fall;
    range_mode_t timing_range_select;
    logic range_reserved;
    logic [5:0] second_cal_length;
    logic [7:0] averaging_cycles;
    logic [2:0] end_event_count;
  } tof_cfg_t;
endpackage : tof_cfg_pkg

// [tof_measurement_config.sv]
`timescale 1ns/1ps
module tof_measurement_config (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic csb_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic meas_done,
  input wire logic meas_aborted,
  output tof_cfg_pkg::tof_cfg_t cfg,
  output logic launch_pulse_out,
  output logic status_clear,
  output logic results_clear,
  output logic run_calibration,
  output logic [7:0] control_value,
  output logic [7:0] setup_value
);
  import tof_cfg_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] s1_q, s2_q, s1_d, s2_d;
  logic sclk_old_q, sclk_old_d;
  always_comb begin
    s1_d = {csb_n, sclk, din};
    s2_d = s1_q;
    sclk_old_d = s2_q[1];
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      // Matches the synchroniser reset so no false edge follows reset
      sclk_old_q <= 1'b1;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      sclk_old_q <= sclk_old_d;
    end
  end
  logic cs_active, sclk_rise;
  assign cs_active = !s2_q[2];
  assign sclk_rise = s2_q[1] && !sclk_old_q;

  // ----------------------------------------
  // Serial frame
  // ----------------------------------------
  // Extra bits after the data byte are ignored; read frames never write.
  logic [3:0] cnt_q, cnt_d;
  logic [14:0] sh_q, sh_d;
  logic full_q, full_d;
  logic wr_stb;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  always_comb begin
    cnt_d = cnt_q;
    sh_d = sh_q;
    full_d = full_q;
    wr_stb = 1'b0;
    // Fifteen bits are held when the last one arrives: address sits below the write bit
    wr_addr = sh_q[12:7];
    wr_data = {sh_q[6:0], s2_q[0]};
    if (!cs_active) begin
      cnt_d = 4'h0;
      full_d = 1'b0;
    end else if (sclk_rise && !full_q) begin
      sh_d = {sh_q[13:0], s2_q[0]};
      cnt_d = cnt_q + 4'h1;
      if (cnt_q == FRAME_BITS) begin
        full_d = 1'b1;
        wr_stb = sh_q[CMD_WRITE_BIT + BITS_PER_BYTE - 1];
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      sh_q <= 15'h0000;
      full_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      full_q <= full_d;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] ctl_q, ctl_d, set_q, set_d;
  logic launch_wr;
  logic [2:0] pulse_q, pulse_d;
  logic stc_q, stc_d, rc_q, rc_d, cal_q, cal_d;
  assign launch_wr = wr_stb && wr_addr == ADDR_CONTROL && wr_data[CTL_LAUNCH];
  always_comb begin
    ctl_d = ctl_q;
    set_d = set_q;
    if (meas_done) begin
      ctl_d[CTL_LAUNCH] = 1'b0;
    end
    if (wr_stb && wr_addr == ADDR_CONTROL) begin
      ctl_d = wr_data;
      if (!wr_data[CTL_LAUNCH]) begin
        ctl_d[CTL_LAUNCH] = ctl_q[CTL_LAUNCH] && !meas_done;
      end
    end
    if (wr_stb && wr_addr == ADDR_SETUP) begin
      set_d = wr_data;
    end
    pulse_d = launch_wr ? 3'(LAUNCH_PULSE_CYCLES) : (pulse_q != 3'h0 ? pulse_q - 3'h1 : 3'h0);
    stc_d = launch_wr;
    rc_d = launch_wr;
    cal_d = meas_done && (!meas_aborted || ctl_q[CTL_FORCE_CAL]);
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= CONTROL_RESET;
      set_q <= SETUP_RESET;
      pulse_q <= 3'h0;
      stc_q <= 1'b0;
      rc_q <= 1'b0;
      cal_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      set_q <= set_d;
      pulse_q <= pulse_d;
      stc_q <= stc_d;
      rc_q <= rc_d;
      cal_q <= cal_d;
    end
  end

  // ----------------------------------------
  // Decoded configuration
  // ----------------------------------------
  tof_cfg_t cfg_q, cfg_d;
  logic lp_q, lp_d;
  always_comb begin
    cfg_d.force_cal = ctl_q[CTL_FORCE_CAL];
    cfg_d.parity_en = ctl_q[CTL_PARITY_EN];
    cfg_d.launch_pulse_polarity = ctl_q[CTL_LAUNCH_POL];
    cfg_d.end_edge_fall = ctl_q[CTL_END_EDGE];
    cfg_d.begin_edge_fall = ctl_q[CTL_BEGIN_EDGE];
    // Reserved codes fall back to mode 2 and are flagged
    cfg_d.timing_range_select = (ctl_q[2:1] == RANGE_SHORT) ? RANGE_MODE_1 : RANGE_MODE_2;
    cfg_d.range_reserved = ctl_q[2:1] != RANGE_SHORT && ctl_q[2:1] != RANGE_LONG;
    case (set_q[7:6])
      2'h0: cfg_d.second_cal_length = CAL2_LEN_0;
      2'h1: cfg_d.second_cal_length = CAL2_LEN_1;
      2'h2: cfg_d.second_cal_length = CAL2_LEN_2;
      default: cfg_d.second_cal_length = CAL2_LEN_3;
    endcase
    cfg_d.averaging_cycles = 8'h01 << set_q[5:3];
    cfg_d.end_event_count = (set_q[2:0] > MAX_END_CODE) ? 3'h1 : set_q[2:0] + 3'h1;
    // Idle level is the inactive side of the chosen edge
    lp_d = (pulse_q != 3'h0) ^ ctl_q[CTL_LAUNCH_POL];
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '0;
      lp_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      lp_q <= lp_d;
    end
  end

  assign cfg = cfg_q;
  assign launch_pulse_out = lp_q;
  assign status_clear = stc_q;
  assign results_clear = rc_q;
  assign run_calibration = cal_q;
  assign control_value = ctl_q;
  assign setup_value = set_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_launch_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    launch_wr |=> status_clear && results_clear) else $error("launch no clear");
  a_launch_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
    launch_wr |=> ##1 (launch_pulse_out != ctl_q[CTL_LAUNCH_POL]))
    else $error("launch pulse missing");
  a_done_clears: assert property (@(posedge sys_clk) disable iff (!rst_b)
    meas_done && !launch_wr |=> !ctl_q[CTL_LAUNCH]) else $error("launch not cleared");
  a_no_cal_abort: assert property (@(posedge sys_clk) disable iff (!rst_b)
    meas_done && meas_aborted && !ctl_q[CTL_FORCE_CAL] |=> !run_calibration)
    else $error("cal after abort");
  a_force_cal: assert property (@(posedge sys_clk) disable iff (!rst_b)
    meas_done && ctl_q[CTL_FORCE_CAL] |=> run_calibration) else $error("forced cal missing");
  a_setup_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_stb && wr_addr == ADDR_SETUP |=> set_q == $past(wr_data))
    else $error("setup write lost");
  a_end_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $past(set_q[2:0]) > MAX_END_CODE |-> cfg.end_event_count == 3'h1)
    else $error("end count wrong");
  a_avg_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
    rst_b |=> cfg.averaging_cycles == (8'h01 << $past(set_q[5:3])))
    else $error("avg wrong");
  a_write_once: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wr_stb |=> !wr_stb) else $error("double write");
  c_launch: cover property (@(posedge sys_clk) disable iff (!rst_b) launch_wr);
  c_setup: cover property (@(posedge sys_clk) disable iff (!rst_b)
    wr_stb && wr_addr == ADDR_SETUP);
  c_done: cover property (@(posedge sys_clk) disable iff (!rst_b)
    ctl_q[CTL_LAUNCH] ##[1:200] meas_done);
endmodule : tof_measurement_config

// [tof_spi_host.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Serial host model
// ----------------------------------------
module tof_spi_host (
  input wire logic sys_clk,
  output logic csb_n,
  output logic sclk,
  output logic din
);
  initial begin
    csb_n = 1'b1;
    sclk = 1'b0;
    din = 1'b1;
  end
  // Clock stands still between frames; din flips so a stale bit never looks valid
  task automatic send(input logic [15:0] frame);
    // Select stays high a few cycles so back-to-back frames are seen apart
    repeat (4) @(negedge sys_clk);
    csb_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din = frame[i];
      repeat (10) @(negedge sys_clk);
      sclk = 1'b1;
      repeat (10) @(negedge sys_clk);
      sclk = 1'b0;
    end
    csb_n = 1'b1;
    din = ~din;
  endtask : send
endmodule : tof_spi_host
